// ===== rtl/sep_defs.svh
// constants for the serial eeprom command port
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_CLK_KHZ 25000
`define SEP_CLK_NS 40
`define SEP_PROG_CYCLE_TIME_MS 5
`define SEP_PROG_CYC (`SEP_PROG_CYCLE_TIME_MS * `SEP_CLK_KHZ)
`define SEP_POWERUP_READ_DELAY_MS 1
`define SEP_POWERUP_WRITE_DELAY_MS 1
`define SEP_PWRUP_CYC (`SEP_POWERUP_WRITE_DELAY_MS * `SEP_CLK_KHZ)
`define SEP_MIN_DESELECT_TIME_NS 1000
`define SEP_DESEL_CYC ((`SEP_MIN_DESELECT_TIME_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_SK_HIGH_MIN_NS 1000
`define SEP_HALF_CYC ((`SEP_SK_HIGH_MIN_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_MEM_BYTES 2048
`define SEP_ABITS_X16 10
`define SEP_ABITS_X8 11
`define SEP_DBITS_X16 16
`define SEP_DBITS_X8 8
`define SEP_ERASED 8'hff
// opcodes and qualifiers of opcode 00
`define SEP_OPC_READ 2'h2
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_ERASE 2'h3
`define SEP_OPC_EXT 2'h0
`define SEP_EXT_WR_EN 2'h3
`define SEP_EXT_WR_DIS 2'h0
`define SEP_EXT_CLR_ALL 2'h2
`define SEP_EXT_WR_ALL 2'h1
// controller register offsets and fields
`define SEP_REG_CMD 8'h00
`define SEP_REG_ADDR 8'h04
`define SEP_REG_WDATA 8'h08
`define SEP_REG_RDATA 8'h0c
`define SEP_REG_STATUS 8'h10
`define SEP_REG_CFG 8'h14
`define SEP_CMD_GO 31
`define SEP_STAT_BUSY 0
`define SEP_STAT_RDY 1
`define SEP_STAT_PWR 2
`define SEP_CFG_X8 0
`define SEP_CFG_X8_RST 1'h0
`endif

// ===== rtl/sep_pkg.sv
// types shared by both ends of the serial eeprom link
`include "sep_defs.svh"
package sep_pkg;
	typedef enum logic [2:0] {
		SEP_CMD_READ    = 3'h0,
		SEP_CMD_WRITE   = 3'h1,
		SEP_CMD_ERASE   = 3'h2,
		SEP_CMD_WR_EN   = 3'h3,
		SEP_CMD_WR_DIS  = 3'h4,
		SEP_CMD_CLR_ALL = 3'h5,
		SEP_CMD_WR_ALL  = 3'h6
	} sep_cmd_t;
	typedef enum logic [5:0] {
		SEP_DS_IDLE = 6'h01,
		SEP_DS_OPC  = 6'h02,
		SEP_DS_ADDR = 6'h04,
		SEP_DS_DATA = 6'h08,
		SEP_DS_READ = 6'h10,
		SEP_DS_DONE = 6'h20
	} sep_dstate_t;
	typedef enum logic [6:0] {
		SEP_HS_PWR   = 7'h01,
		SEP_HS_IDLE  = 7'h02,
		SEP_HS_SEND  = 7'h04,
		SEP_HS_RECV  = 7'h08,
		SEP_HS_GAP   = 7'h10,
		SEP_HS_POLL  = 7'h20,
		SEP_HS_DUMMY = 7'h40
	} sep_hstate_t;
	typedef struct packed {
		logic [`SEP_MEM_BYTES-1:0][7:0] mem;
		sep_dstate_t                    st;
		logic                           sclk_q;
		logic                           cs_q;
		logic [1:0]                     opc;
		logic [10:0]                    addr;
		logic [15:0]                    sh;
		logic [4:0]                     cnt;
		logic                           wen;
		logic                           stat_pend;
		logic                           rel_pend;
		logic [23:0]                    prog;
		logic                           busy;
		logic                           dout;
		logic                           dout_oe;
	} sep_dev_st_t;
	typedef struct packed {
		sep_hstate_t st;
		logic        cs;
		logic        sclk;
		logic        sdin;
		logic [31:0] frame;
		logic [5:0]  nb;
		logic [15:0] rd;
		logic [23:0] tm;
		logic        isrd;
		logic        poll;
		logic        rdy;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [2:0]  cmd;
		logic [10:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        x8;
	} sep_host_st_t;
endpackage

// ===== rtl/sep_link_if.sv
// serial link between controller and eeprom command port
`timescale 1ns/1ns
`default_nettype none
interface sep_link_if;
	logic cs;
	logic serial_clock_in;
	logic serial_data_in;
	logic dev_do;
	logic dev_do_oe;
	logic dout_line;
	// released line is held high by a pull-up
	assign dout_line = dev_do_oe ? dev_do : 1'h1;
	modport dev (
		input  cs,
		input  serial_clock_in,
		input  serial_data_in,
		output dev_do,
		output dev_do_oe
	);
	modport host (
		output cs,
		output serial_clock_in,
		output serial_data_in,
		input  dout_line
	);
endinterface
`default_nettype wire

// ===== rtl/sep_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sep_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic [W-1:0]      q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sep_sync_st_t;
	sep_sync_st_t r;
	sep_sync_st_t n;

	// first stage feeds only the second
	always_comb begin
		n.s1 = d_i;
		n.s2 = r.s1;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q_o = r.s2;
endmodule
`default_nettype wire

// ===== rtl/sep_device.sv
// eeprom end: command decoder, array, read shifter and status output
`timescale 1ns/1ns
`default_nettype none
`include "sep_defs.svh"
// Overview of operation
// - start bit, opcode, address, optional data
// - opcode 10 reads, 01 writes
// - 11 clears; 00 qualified by two bits
// - input bits taken on clock rise
// - output released except read or status
// - selected after program: low busy, high ready
// - dummy one releases status output
// - status output released on clock fall
// - host clocks a dummy one after polling
// - program enable gates array changing commands
// - read sends dummy zero then word
// - read bits change on clock rise
// - sequential read advances, wraps to zero
// - dummy zero only before first word
// - host waits power-up delay before commands
// - deselect starts self-timed program cycle
// - width select: high x16, low x8
// - powers up write disabled
// - erase sets bits to one
module sep_device #(
	parameter logic [23:0] PROG_CYCLES = 24'(`SEP_PROG_CYC)
) (
	input  wire logic     CORE_CLK_I,
	input  wire logic     RST_I,
	input  wire logic     ORGANISATION_SELECT_I,
	input  wire logic     PROGRAM_ENABLE_IN_I,
	output logic          BUSY_O,
	sep_link_if.dev       link
);
	localparam logic [4:0] AL8 = 5'(`SEP_ABITS_X8 - 1);
	localparam logic [4:0] AL16 = 5'(`SEP_ABITS_X16 - 1);
	localparam logic [4:0] DB8 = 5'(`SEP_DBITS_X8);
	localparam logic [4:0] DB16 = 5'(`SEP_DBITS_X16);

	sep_pkg::sep_dev_st_t r;
	sep_pkg::sep_dev_st_t n;
	logic [4:0]  raw;
	logic [4:0]  syn;
	logic        cs_s;
	logic        sclk_s;
	logic        sdin_s;
	logic        pen_s;
	logic        x8;
	logic        rise;
	logic        fall;
	logic [4:0]  dbits;
	logic [1:0]  t2;
	logic [1:0]  t2n;
	logic [10:0] amask;
	logic [10:0] idx;
	logic [10:0] na;
	logic [15:0] word;
	logic        wtype;

	// read one word, left aligned; x16 holds high byte at even index
	function automatic logic [15:0] rdword(input logic [10:0] a, input logic w8,
		input sep_pkg::sep_dev_st_t s);
		logic [10:0] i;
		i = {a[9:0], 1'h0};
		if (w8) begin
			rdword = {s.mem[a], 8'h00};
		end else begin
			rdword = {s.mem[i], s.mem[i | 11'h001]};
		end
	endfunction

	// every pin passes two flip-flops
	assign raw = {link.cs, link.serial_clock_in, link.serial_data_in,
		ORGANISATION_SELECT_I, PROGRAM_ENABLE_IN_I};
	sep_sync #(
		.W(5)
	) u_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.d_i  (raw),
		.q_o  (syn)
	);
	assign cs_s = syn[4];
	assign sclk_s = syn[3];
	assign sdin_s = syn[2];
	assign pen_s = syn[0];

	// next-state logic
	always_comb begin
		n = r;
		x8 = ~syn[1];
		dbits = x8 ? DB8 : DB16;
		amask = x8 ? 11'h7ff : 11'h3ff;
		t2 = x8 ? r.addr[10:9] : r.addr[9:8];
		t2n = 2'h0;
		idx = x8 ? r.addr : {r.addr[9:0], 1'h0};
		na = 11'h000;
		word = 16'h0000;
		rise = sclk_s & ~r.sclk_q;
		fall = ~sclk_s & r.sclk_q;
		wtype = (r.opc != `SEP_OPC_READ)
			&& !(r.opc == `SEP_OPC_EXT && (t2 == `SEP_EXT_WR_EN || t2 == `SEP_EXT_WR_DIS));
		n.sclk_q = sclk_s;
		n.cs_q = cs_s;
		// self-timed program interval
		if (r.prog != 24'h000000) begin
			n.prog = r.prog - 24'h000001;
		end
		if (!cs_s) begin
			// deselect drops any partial frame and the output
			n.st = sep_pkg::SEP_DS_IDLE;
			n.dout_oe = 1'h0;
			n.rel_pend = 1'h0;
			// falling select starts the program cycle
			if (r.cs_q && r.st == sep_pkg::SEP_DS_DONE && wtype && r.wen && pen_s
				&& r.prog == 24'h000000) begin
				n.prog = PROG_CYCLES;
				n.stat_pend = 1'h1;
				unique case (r.opc)
					`SEP_OPC_WRITE: begin
						if (x8) begin
							n.mem[idx] = r.sh[7:0];
						end else begin
							n.mem[idx] = r.sh[15:8];
							n.mem[idx | 11'h001] = r.sh[7:0];
						end
					end
					`SEP_OPC_ERASE: begin
						n.mem[idx] = `SEP_ERASED;
						if (!x8) begin
							n.mem[idx | 11'h001] = `SEP_ERASED;
						end
					end
					default: begin
						// fill every location
						for (int i = 0; i < `SEP_MEM_BYTES; i++) begin
							if (t2 == `SEP_EXT_CLR_ALL) begin
								n.mem[i] = `SEP_ERASED;
							end else if (x8 || (i % 2) == 1) begin
								n.mem[i] = r.sh[7:0];
							end else begin
								n.mem[i] = r.sh[15:8];
							end
						end
					end
				endcase
			end
		end else begin
			// status shown while selected after a program start
			if (r.stat_pend && r.st == sep_pkg::SEP_DS_IDLE) begin
				n.dout_oe = 1'h1;
				n.dout = (r.prog == 24'h000000);
			end
			// release after the dummy one, on the clock fall
			if (r.rel_pend && fall) begin
				n.rel_pend = 1'h0;
				n.stat_pend = 1'h0;
				n.dout_oe = 1'h0;
			end
			// serial input sampled on clock rise
			if (rise) begin
				unique case (r.st)
					sep_pkg::SEP_DS_IDLE: begin
						if (sdin_s) begin
							n.rel_pend = r.stat_pend;
							if (r.prog == 24'h000000) begin
								n.st = sep_pkg::SEP_DS_OPC;
								n.cnt = 5'h00;
							end
						end
					end
					sep_pkg::SEP_DS_OPC: begin
						n.opc = {r.opc[0], sdin_s};
						n.cnt = r.cnt + 5'h01;
						if (r.cnt == 5'h01) begin
							n.st = sep_pkg::SEP_DS_ADDR;
							n.cnt = 5'h00;
							n.addr = 11'h000;
						end
					end
					sep_pkg::SEP_DS_ADDR: begin
						n.addr = {r.addr[9:0], sdin_s};
						n.cnt = r.cnt + 5'h01;
						t2n = x8 ? n.addr[10:9] : n.addr[9:8];
						if (r.cnt == (x8 ? AL8 : AL16)) begin
							n.st = sep_pkg::SEP_DS_DONE;
							n.cnt = 5'h00;
							unique case (r.opc)
								`SEP_OPC_READ: begin
									// dummy zero ahead of the first word
									n.st = sep_pkg::SEP_DS_READ;
									n.sh = rdword(n.addr, x8, r);
									n.cnt = dbits;
									n.dout = 1'h0;
									n.dout_oe = 1'h1;
								end
								`SEP_OPC_WRITE: begin
									n.st = sep_pkg::SEP_DS_DATA;
								end
								`SEP_OPC_ERASE: begin
									n.st = sep_pkg::SEP_DS_DONE;
								end
								default: begin
									// qualifier in the two leading bits
									if (t2n == `SEP_EXT_WR_EN) begin
										n.wen = 1'h1;
									end else if (t2n == `SEP_EXT_WR_DIS) begin
										n.wen = 1'h0;
									end else if (t2n == `SEP_EXT_WR_ALL) begin
										n.st = sep_pkg::SEP_DS_DATA;
									end
								end
							endcase
						end
					end
					sep_pkg::SEP_DS_DATA: begin
						n.sh = {r.sh[14:0], sdin_s};
						n.cnt = r.cnt + 5'h01;
						if (r.cnt == dbits - 5'h01) begin
							n.st = sep_pkg::SEP_DS_DONE;
						end
					end
					sep_pkg::SEP_DS_READ: begin
						if (r.cnt == 5'h00) begin
							// next word follows with no dummy bit
							na = (r.addr + 11'h001) & amask;
							word = rdword(na, x8, r);
							n.addr = na;
							n.dout = word[15];
							n.sh = {word[14:0], 1'h0};
							n.cnt = dbits - 5'h01;
						end else begin
							n.dout = r.sh[15];
							n.sh = {r.sh[14:0], 1'h0};
							n.cnt = r.cnt - 5'h01;
						end
					end
					sep_pkg::SEP_DS_DONE: begin
						// surplus clocks wait for the deselect
						n.st = sep_pkg::SEP_DS_DONE;
					end
				endcase
			end
		end
		n.busy = (n.prog != 24'h000000);
	end

	// state register; array cleared and writes disabled at reset
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			r <= '0;
			r.st <= sep_pkg::SEP_DS_IDLE;
		end else begin
			r <= n;
		end
	end

	assign link.dev_do = r.dout;
	assign link.dev_do_oe = r.dout_oe;
	assign BUSY_O = r.busy;
endmodule
`default_nettype wire

// ===== rtl/sep_host.sv
// controller end: apb registers drive framed commands onto the link
`timescale 1ns/1ns
`default_nettype none
`include "sep_defs.svh"
module sep_host #(
	parameter logic [23:0] PWRUP_CYCLES = 24'(`SEP_PWRUP_CYC)
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	sep_link_if.host         link
);
	localparam logic [23:0] HALF = 24'(`SEP_HALF_CYC - 1);
	localparam logic [23:0] DESEL = 24'(`SEP_DESEL_CYC - 1);

	sep_pkg::sep_host_st_t r;
	sep_pkg::sep_host_st_t n;
	logic        dout_s;
	logic        tick;
	logic        commit;
	logic [1:0]  opc;
	logic [1:0]  t2;
	logic        ext;
	logic        dat;
	logic [10:0] af;

	sep_sync #(
		.W(1)
	) u_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.d_i  (link.dout_line),
		.q_o  (dout_s)
	);

	always_comb begin
		n = r;
		tick = (r.tm == 24'h000000);
		commit = PSEL_I & PENABLE_I & r.pready;
		opc = `SEP_OPC_READ;
		t2 = 2'h0;
		ext = 1'h0;
		dat = 1'h0;
		af = 11'h000;
		if (!tick) begin
			n.tm = r.tm - 24'h000001;
		end
		// apb: ready one cycle into the access phase
		n.pready = PSEL_I & PENABLE_I & ~r.pready;
		n.pslverr = 1'h0;
		n.prdata = 32'h00000000;
		if (n.pready) begin
			unique case (PADDR_I)
				`SEP_REG_CMD: n.prdata = {29'h0, r.cmd};
				`SEP_REG_ADDR: n.prdata = {21'h0, r.addr};
				`SEP_REG_WDATA: n.prdata = {16'h0, r.wdata};
				`SEP_REG_RDATA: n.prdata = {16'h0, r.rdata};
				`SEP_REG_STATUS: n.prdata = {29'h0, r.st != sep_pkg::SEP_HS_PWR, r.rdy,
					r.st != sep_pkg::SEP_HS_IDLE};
				`SEP_REG_CFG: n.prdata = {31'h0, r.x8};
				default: n.pslverr = 1'h1;
			endcase
		end
		// register writes take effect at the ready edge
		if (commit && PWRITE_I) begin
			unique case (PADDR_I)
				`SEP_REG_ADDR: n.addr = PWDATA_I[10:0];
				`SEP_REG_WDATA: n.wdata = PWDATA_I[15:0];
				`SEP_REG_CFG: n.x8 = PWDATA_I[`SEP_CFG_X8];
				default: ;
			endcase
		end
		// a go request builds the whole frame
		if (commit && PWRITE_I && PADDR_I == `SEP_REG_CMD) begin
			n.cmd = PWDATA_I[2:0];
			unique case (PWDATA_I[2:0])
				sep_pkg::SEP_CMD_READ: opc = `SEP_OPC_READ;
				sep_pkg::SEP_CMD_WRITE: begin
					opc = `SEP_OPC_WRITE;
					dat = 1'h1;
				end
				sep_pkg::SEP_CMD_ERASE: opc = `SEP_OPC_ERASE;
				sep_pkg::SEP_CMD_WR_EN: t2 = `SEP_EXT_WR_EN;
				sep_pkg::SEP_CMD_WR_DIS: t2 = `SEP_EXT_WR_DIS;
				sep_pkg::SEP_CMD_CLR_ALL: t2 = `SEP_EXT_CLR_ALL;
				default: begin
					t2 = `SEP_EXT_WR_ALL;
					dat = 1'h1;
				end
			endcase
			ext = (PWDATA_I[2:0] > 3'h2);
			if (ext) begin
				opc = `SEP_OPC_EXT;
			end
			if (PWDATA_I[`SEP_CMD_GO] && r.st == sep_pkg::SEP_HS_IDLE) begin
				af = ext ? {t2, 9'h000} : r.addr;
				n.frame = r.x8 ? {1'h1, opc, af, r.wdata[7:0], 10'h000}
					: {1'h1, opc, (ext ? {t2, 8'h00} : r.addr[9:0]), r.wdata, 3'h0};
				n.nb = r.x8 ? (dat ? 6'd22 : 6'd14) : (dat ? 6'd29 : 6'd13);
				n.isrd = (PWDATA_I[2:0] == sep_pkg::SEP_CMD_READ);
				n.poll = ~ext | (t2 == `SEP_EXT_CLR_ALL) | (t2 == `SEP_EXT_WR_ALL);
				n.poll = n.poll & ~n.isrd;
				n.rdy = 1'h0;
				n.cs = 1'h1;
				n.sdin = 1'h1;
				n.sclk = 1'h0;
				n.tm = HALF;
				n.st = sep_pkg::SEP_HS_SEND;
			end
		end
		// link sequencer; every step waits one timer period
		unique case (r.st)
			sep_pkg::SEP_HS_PWR: begin
				if (tick) begin
					n.st = sep_pkg::SEP_HS_IDLE;
				end
			end
			sep_pkg::SEP_HS_IDLE: ;
			sep_pkg::SEP_HS_SEND: begin
				if (tick) begin
					n.tm = HALF;
					n.sclk = ~r.sclk;
					if (r.sclk) begin
						// new bit while the clock is low
						n.frame = {r.frame[30:0], 1'h0};
						n.sdin = r.frame[30];
						n.nb = r.nb - 6'h01;
						if (r.nb == 6'h01) begin
							n.sdin = 1'h0;
							n.nb = r.x8 ? 6'd8 : 6'd16;
							n.st = sep_pkg::SEP_HS_RECV;
							if (!r.isrd) begin
								n.cs = 1'h0;
								n.tm = DESEL;
								n.st = sep_pkg::SEP_HS_GAP;
							end
						end
					end
				end
			end
			sep_pkg::SEP_HS_RECV: begin
				if (tick) begin
					n.tm = HALF;
					n.sclk = ~r.sclk;
					if (r.sclk) begin
						// sample on the fall, half a period after change
						n.rd = {r.rd[14:0], dout_s};
						n.nb = r.nb - 6'h01;
						if (r.nb == 6'h01) begin
							n.rdata = r.x8 ? {8'h00, n.rd[7:0]} : n.rd;
							n.cs = 1'h0;
							n.tm = DESEL;
							n.st = sep_pkg::SEP_HS_GAP;
						end
					end
				end
			end
			sep_pkg::SEP_HS_GAP: begin
				if (tick) begin
					n.st = sep_pkg::SEP_HS_IDLE;
					if (r.poll) begin
						n.cs = 1'h1;
						n.tm = DESEL;
						n.st = sep_pkg::SEP_HS_POLL;
					end
				end
			end
			sep_pkg::SEP_HS_POLL: begin
				if (tick && dout_s) begin
					n.rdy = 1'h1;
					n.poll = 1'h0;
					n.sdin = 1'h1;
					n.tm = HALF;
					n.st = sep_pkg::SEP_HS_DUMMY;
				end
			end
			sep_pkg::SEP_HS_DUMMY: begin
				if (tick) begin
					n.tm = HALF;
					if (r.sdin) begin
						n.sclk = ~r.sclk;
						if (r.sclk) begin
							// clock fall releases the line, select still high
							n.sdin = 1'h0;
						end
					end else begin
						// deselect half a period after the release
						n.cs = 1'h0;
						n.tm = DESEL;
						n.st = sep_pkg::SEP_HS_GAP;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			r <= '0;
			r.st <= sep_pkg::SEP_HS_PWR;
			r.tm <= PWRUP_CYCLES;
		end else begin
			r <= n;
		end
	end

	assign PRDATA_O = r.prdata;
	assign PREADY_O = r.pready;
	assign PSLVERR_O = r.pslverr;
	assign link.cs = r.cs;
	assign link.serial_clock_in = r.sclk;
	assign link.serial_data_in = r.sdin;
endmodule
`default_nettype wire

// ===== dv/sep_link_monitor.sv
// concurrent checks on the serial link between controller and eeprom end
`timescale 1ns/1ns
`default_nettype none
module sep_link_monitor #(
	parameter logic [23:0] PROG_CYCLES = 24'd200
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic BUSY_O,
	input wire logic cs,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic dev_do,
	input wire logic dev_do_oe,
	input wire logic dout_line
);
	logic [23:0] busy_cnt_r;

	default clocking mon_cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);

	// ****************************************
	// helper: length of the current busy interval
	// ****************************************
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I)
			busy_cnt_r <= 24'h0;
		else if (BUSY_O)
			busy_cnt_r <= busy_cnt_r + 24'h1;
		else
			busy_cnt_r <= 24'h0;
	end

	// ****************************************
	// link assertions
	// ****************************************
	AST_IDLE_RELEASED: assert property ((!cs)[*6] |-> !dev_do_oe)
		else $error("data output driven while deselected");
	AST_BUSY_LOW_OUT: assert property (cs && BUSY_O && dev_do_oe |-> !dout_line)
		else $error("status not low while busy");
	AST_READY_HIGH: assert property ($fell(BUSY_O) && cs |-> ##[0:6] (dout_line || !cs))
		else $error("status not high after program end");
	AST_STATUS_RELEASE_FALL: assert property ($fell(dev_do_oe) && cs |-> !serial_clock_in)
		else $error("status released outside clock low phase");
	AST_READ_BIT_ON_RISE: assert property (
		dev_do_oe && $past(dev_do_oe) && $changed(dev_do) && cs && !BUSY_O && !$past(BUSY_O, 4)
		|-> serial_clock_in)
		else $error("read bit changed outside clock high phase");
	AST_SDIN_STABLE_HIGH: assert property (serial_clock_in && $past(serial_clock_in)
		|-> $stable(serial_data_in))
		else $error("input bit moved while clock high");
	AST_SK_HIGH_WIDTH: assert property ($rose(serial_clock_in) |-> serial_clock_in[*8])
		else $error("serial clock high phase too short");
	AST_CLOCK_STILL: assert property (!cs |-> !serial_clock_in)
		else $error("serial clock running outside frame");
	AST_BUSY_ON_DESELECT: assert property ($rose(BUSY_O) |-> !cs ##1 BUSY_O[*8])
		else $error("program cycle not started by deselect");
	AST_BUSY_SPAN: assert property ($fell(BUSY_O) |->
		(busy_cnt_r + 24'd2 >= PROG_CYCLES) && (busy_cnt_r <= PROG_CYCLES + 24'd2))
		else $error("program interval length wrong");
endmodule
`default_nettype wire

// ===== dv/serial_eeprom_command_port_test.sv
// self-checking bench: apb controller driving the eeprom end over the link
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_command_port_test;
	typedef struct packed {
		logic [2:0]  cmd;
		logic [10:0] addr;
		logic [15:0] wd;
		logic        pe;
		logic        rd;
		logic [15:0] exp;
	} sep_row_t;
	logic        core_clk = 1'h0;
	logic        rst      = 1'h1;
	logic        psel     = 1'h0;
	logic        penable  = 1'h0;
	logic        pwrite   = 1'h0;
	logic [7:0]  paddr    = 8'h0;
	logic [31:0] pwdata   = 32'h0;
	logic        org_r    = 1'h1;
	logic        pe_r     = 1'h1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [31:0] rdat;
	logic        serr;
	int          err_total = 0;
	int          n_checks  = 0;
	// cmd, addr, data, program enable, read back, expected word
	sep_row_t rows[12] = '{
		'{3'h1, 11'h005, 16'h1234, 1'h1, 1'h1, 16'h0000},
		'{3'h3, 11'h000, 16'h0000, 1'h0, 1'h0, 16'h0000},
		'{3'h1, 11'h005, 16'h1234, 1'h1, 1'h1, 16'h1234},
		'{3'h1, 11'h006, 16'ha5c3, 1'h0, 1'h1, 16'h0000},
		'{3'h1, 11'h006, 16'ha5c3, 1'h1, 1'h1, 16'ha5c3},
		'{3'h2, 11'h005, 16'h0000, 1'h1, 1'h1, 16'hffff},
		'{3'h6, 11'h3ff, 16'h5a5a, 1'h1, 1'h1, 16'h5a5a},
		'{3'h5, 11'h000, 16'h0000, 1'h1, 1'h1, 16'hffff},
		'{3'h4, 11'h000, 16'h0000, 1'h1, 1'h0, 16'h0000},
		'{3'h1, 11'h3ff, 16'h7777, 1'h1, 1'h1, 16'hffff},
		'{3'h3, 11'h000, 16'h0000, 1'h1, 1'h0, 16'h0000},
		'{3'h1, 11'h3ff, 16'h0001, 1'h1, 1'h1, 16'h0001}
	};

	sep_link_if u_sep_link_if ();
	sep_device #(.PROG_CYCLES(24'd200)) u_sep_device (
		.CORE_CLK_I            (core_clk),
		.RST_I                 (rst),
		.ORGANISATION_SELECT_I (org_r),
		.PROGRAM_ENABLE_IN_I   (pe_r),
		.BUSY_O                (busy),
		.link                  (u_sep_link_if)
	);
	sep_host #(.PWRUP_CYCLES(24'd50)) u_sep_host (
		.CORE_CLK_I (core_clk),
		.RST_I      (rst),
		.PSEL_I     (psel),
		.PENABLE_I  (penable),
		.PWRITE_I   (pwrite),
		.PADDR_I    (paddr),
		.PWDATA_I   (pwdata),
		.PRDATA_O   (prdata),
		.PREADY_O   (pready),
		.PSLVERR_O  (pslverr),
		.link       (u_sep_link_if)
	);
	sep_link_monitor #(.PROG_CYCLES(24'd200)) u_sep_link_monitor (
		.CORE_CLK_I      (core_clk),
		.RST_I           (rst),
		.BUSY_O          (busy),
		.cs              (u_sep_link_if.cs),
		.serial_clock_in (u_sep_link_if.serial_clock_in),
		.serial_data_in  (u_sep_link_if.serial_data_in),
		.dev_do          (u_sep_link_if.dev_do),
		.dev_do_oe       (u_sep_link_if.dev_do_oe),
		.dout_line       (u_sep_link_if.dout_line)
	);

	// ****************************************
	// clock, shared tasks
	// ****************************************
	always #20 core_clk = ~core_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		// answer taken at the edge that samples pready high
		rdat = prdata;
		serr = pslverr;
		if (pready !== 1'h1) begin
			err_total++;
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// poll status until the selected bit reads the wanted level
	task automatic wait_stat(input int bit_no, input logic lvl);
		int n;
		n = 0;
		do begin
			apb(1'h0, 8'h10, 32'h0);
			n++;
		end while (rdat[bit_no] !== lvl && n < 3000);
		// a poll limit that runs out counts as a mismatch
		if (rdat[bit_no] !== lvl) begin
			err_total++;
		end
	endtask

	task automatic run_cmd(input logic [2:0] c, input logic [10:0] a, input logic [15:0] d);
		apb(1'h1, 8'h04, {21'h0, a});
		apb(1'h1, 8'h08, {16'h0, d});
		apb(1'h1, 8'h00, {1'h1, 28'h0, c});
		wait_stat(0, 1'h0);
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		#(40 * 90000);
		err_total++;
		conclude();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		apb(1'h0, 8'h10, 32'h0);
		check({29'h0, rdat[2:0]}, 32'h1);
		apb(1'h0, 8'h14, 32'h0);
		check(rdat, 32'h0);
		wait_stat(2, 1'h1);
		// table of ordinary commands, read back where the row's read-back flag is set
		for (int i = 0; i < 12; i++) begin
			pe_r <= rows[i].pe;
			run_cmd(rows[i].cmd, rows[i].addr, rows[i].wd);
			if (rows[i].rd) begin
				run_cmd(3'h0, rows[i].addr, 16'h0);
				apb(1'h0, 8'h0c, 32'h0);
				check(rdat, {16'h0, rows[i].exp});
			end
		end
		// unmapped offset is refused
		apb(1'h0, 8'h18, 32'h0);
		check({31'h0, serr}, 32'h1);
		check(rdat, 32'h0);
		// byte organisation reaches the low half of word 5
		org_r <= 1'h0;
		apb(1'h1, 8'h14, 32'h1);
		run_cmd(3'h1, 11'h00b, 16'h003c);
		// ready flag stands after a polled write, cleared by the next go
		apb(1'h0, 8'h10, 32'h0);
		check({29'h0, rdat[2:0]}, 32'h6);
		run_cmd(3'h0, 11'h00a, 16'h0);
		apb(1'h0, 8'h0c, 32'h0);
		check(rdat, 32'hff);
		org_r <= 1'h1;
		apb(1'h1, 8'h14, 32'h0);
		run_cmd(3'h0, 11'h005, 16'h0);
		apb(1'h0, 8'h0c, 32'h0);
		check(rdat, 32'hff3c);
		// second reset: write protection returns
		@(posedge core_clk);
		rst <= 1'h1;
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		wait_stat(2, 1'h1);
		run_cmd(3'h1, 11'h005, 16'h1111);
		run_cmd(3'h0, 11'h005, 16'h0);
		apb(1'h0, 8'h0c, 32'h0);
		check(rdat, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
